// ===== sdc_flag.sv
`timescale 1ns/10ps
`default_nettype none

// Sticky status flag; a set in the same cycle as a clear wins
module sdc_flag
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	// ****************************************************************
	// Flag storage
	// ****************************************************************
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clr_i)
			flag_o <= 1'b0;
	end
endmodule // sdc_flag

`default_nettype wire

// ===== sdc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Debug host: one command a call, read answer collected
module sdc_host_model
(
	input  wire logic              core_clk_i,
	input  wire logic              rvalid_i,
	input  wire logic [15:0]       rdata_i,
	output sdc_pkg::sdc_cmd_s      cmd_o
);
	import sdc_pkg::*;

	initial cmd_o = '0;

	// Valid lasts one cycle, else the command is taken twice
	task automatic issue(input logic [7:0] code, input logic [15:0] wd, output logic [15:0] rd);
		rd = 'x;
		@(posedge core_clk_i);
		cmd_o <= '{valid: 1'b1, code: code, wdata: wd};
		@(posedge core_clk_i);
		cmd_o <= '{valid: 1'b0, code: ~code, wdata: ~wd};
		repeat (3)
		begin
			#1;
			if (rvalid_i === 1'b1)
				rd = rdata_i;
			@(posedge core_clk_i);
		end
	endtask
endmodule // sdc_host_model

`default_nettype wire

// ===== sdc_match.sv
`timescale 1ns/10ps
`default_nettype none

// Breakpoint address comparator, registered one cycle
module sdc_match
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        enable_i,
	input  wire logic        addr_valid_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] match_i,
	output logic             hit_o
);
	// ****************************************************************
	// Compare
	// ****************************************************************
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			hit_o <= 1'b0;
		else
			hit_o <= enable_i && addr_valid_i && (addr_i == match_i);
	end
endmodule // sdc_match

`default_nettype wire

// ===== sdc_pkg.sv
package sdc_pkg;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] SDC_CMD_STATUS_READ  = 8'hE4;
	localparam logic [7:0] SDC_CMD_CONTROL_WR   = 8'hC4;
	localparam logic [7:0] SDC_CMD_BREAK_READ   = 8'hE2;
	localparam logic [7:0] SDC_CMD_BREAK_WR     = 8'hC2;

	// ****************************************************************
	// Status and control field positions
	// ****************************************************************
	localparam int SDC_BIT_HALT_PERMIT  = 7;
	localparam int SDC_BIT_HALTED       = 6;
	localparam int SDC_BIT_BREAK_EN     = 5;
	localparam int SDC_BIT_FORCE_SEL    = 4;
	localparam int SDC_BIT_CLK_SEL      = 3;
	localparam int SDC_BIT_SLEEP        = 2;
	localparam int SDC_BIT_SLEEP_FAIL   = 1;
	localparam int SDC_BIT_SLOW_FAIL    = 0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic        SDC_RST_CTRL_BIT = 1'b0;
	localparam logic [15:0] SDC_RST_BREAK    = 16'h0000;
	localparam logic [7:0]  SDC_RST_RDATA    = 8'h00;

	// Command presented by the serial command decoder
	typedef struct packed {
		logic        valid;
		logic [7:0]  code;
		logic [15:0] wdata;
	} sdc_cmd_s;

	// CPU status and bus view
	typedef struct packed {
		logic        halted;
		logic        sleeping;
		logic        addr_valid;
		logic [15:0] addr;
	} sdc_cpu_s;

endpackage

// ===== sdc_regs.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Eight-bit status and control register kept.
// - Sixteen-bit breakpoint match address register kept.
// - Registers reachable only by serial commands.
// - Halt permit frozen while halted.
// - Status bits never written by control write.
// - Clock select free read-write, resets zero.
// - Halt permit stays set until reset.
// - Halt refused while permit clear.
// - Halted flag mirrors halted debug mode.
// - Breakpoint disabled means no requests after two cycles off; a registered hit or pending force can still fire.
// - Force mode halts at instruction boundary.
// - Tag mode marks opcode, halts at queue end.
// - Sleep status shows wait/stop or halt from it.
// - Halt request still works from wait/stop.
// - Sleep fail set on conflicting memory access.
// - Slow access fail always reads zero.
// - Status read and control write only paths.
// - Break read and break write access match.
// - Command codes E4, C4, E2, C2.
// - Break enable resets to zero.
module sdc_regs
(
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire sdc_pkg::sdc_cmd_s cmd_i,
	input  wire sdc_pkg::sdc_cpu_s cpu_i,
	input  wire logic             halt_req_i,
	input  wire logic             insn_boundary_i,
	input  wire logic             queue_end_i,
	input  wire logic             mem_cmd_i,
	input  wire logic             sleep_conflict_i,
	output logic                  rvalid_o,
	output logic [15:0]           rdata_o,
	output logic                  enter_halt_o,
	output logic                  force_break_o,
	output logic                  tag_opcode_o,
	output logic                  clk_sel_o
);
	import sdc_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	logic        halt_permit_r;
	logic        break_en_r;
	logic        force_sel_r;
	logic [15:0] break_match_r;
	logic        halt_from_sleep_r;
	logic        sleep_fail;
	logic        hit;
	logic        force_pend_r;
	logic [7:0]  status;
	logic        ctrl_wr;
	logic        brk_wr;
	logic        stat_rd;

	// Decode of the only access paths; no memory map exists
	assign stat_rd = cmd_i.valid && (cmd_i.code == SDC_CMD_STATUS_READ);
	assign ctrl_wr = cmd_i.valid && (cmd_i.code == SDC_CMD_CONTROL_WR);
	assign brk_wr  = cmd_i.valid && (cmd_i.code == SDC_CMD_BREAK_WR);

	// Halt permit: set-only by the host, frozen while halted
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			halt_permit_r <= SDC_RST_CTRL_BIT;
		else if (ctrl_wr && !cpu_i.halted && cmd_i.wdata[SDC_BIT_HALT_PERMIT])
			halt_permit_r <= 1'b1;
	end

	// Breakpoint controls and clock select, free to write
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			break_en_r  <= SDC_RST_CTRL_BIT;
			force_sel_r <= SDC_RST_CTRL_BIT;
			clk_sel_o   <= SDC_RST_CTRL_BIT;
		end
		else if (ctrl_wr)
		begin
			break_en_r  <= cmd_i.wdata[SDC_BIT_BREAK_EN];
			force_sel_r <= cmd_i.wdata[SDC_BIT_FORCE_SEL];
			clk_sel_o   <= cmd_i.wdata[SDC_BIT_CLK_SEL];
		end
	end

	// Breakpoint match address
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			break_match_r <= SDC_RST_BREAK;
		else if (brk_wr)
			break_match_r <= cmd_i.wdata;
	end

	// Remembers that halted mode was entered out of wait or stop
	// Kept through the gap before the CPU reports halted; dropped once it runs again
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			halt_from_sleep_r <= 1'b0;
		else if (enter_halt_o && cpu_i.sleeping)
			halt_from_sleep_r <= 1'b1;
		else if (!cpu_i.halted && !cpu_i.sleeping && !enter_halt_o)
			halt_from_sleep_r <= 1'b0;
	end

	// Sleep failure: set by a clashing access, cleared by the next halt entry request (enter_halt_o)
	sdc_flag u_sleep_fail
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.set_i      (mem_cmd_i && sleep_conflict_i),
		.clr_i      (enter_halt_o),
		.flag_o     (sleep_fail)
	);

	// Comparator gated by the enable; hit lags it one cycle, so a hit can still fire in the first cycle it is off
	sdc_match u_match
	(
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.enable_i     (break_en_r),
		.addr_valid_i (cpu_i.addr_valid),
		.addr_i       (cpu_i.addr),
		.match_i      (break_match_r),
		.hit_o        (hit)
	);

	// Forced breakpoint waits for the next instruction boundary
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			force_pend_r <= 1'b0;
		else if (!break_en_r || cpu_i.halted)
			force_pend_r <= 1'b0;
		else if (hit && force_sel_r)
			force_pend_r <= 1'b1;
	end

	// ****************************************************************
	// Status byte
	// ****************************************************************
	// Read-only bits come from live state, never from the write
	always_comb
	begin
		status = 8'h00;
		status[SDC_BIT_HALT_PERMIT] = halt_permit_r;
		status[SDC_BIT_HALTED]      = cpu_i.halted;
		status[SDC_BIT_BREAK_EN]    = break_en_r;
		status[SDC_BIT_FORCE_SEL]   = force_sel_r;
		status[SDC_BIT_CLK_SEL]     = clk_sel_o;
		status[SDC_BIT_SLEEP]       = cpu_i.sleeping || (cpu_i.halted && halt_from_sleep_r);
		status[SDC_BIT_SLEEP_FAIL]  = sleep_fail;
		status[SDC_BIT_SLOW_FAIL]   = 1'b0;
	end

	// Read answer registered one cycle after the command
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rvalid_o <= 1'b0;
			rdata_o  <= {SDC_RST_RDATA, SDC_RST_RDATA};
		end
		else
		begin
			rvalid_o <= stat_rd || (cmd_i.valid && (cmd_i.code == SDC_CMD_BREAK_READ));
			if (stat_rd)
				rdata_o <= {SDC_RST_RDATA, status};
			else if (cmd_i.valid && (cmd_i.code == SDC_CMD_BREAK_READ))
				rdata_o <= break_match_r;
		end
	end

	// ****************************************************************
	// Halt requests to the CPU
	// ****************************************************************
	// Every entry into halted mode needs the permit; wait/stop does not block it
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			enter_halt_o  <= 1'b0;
			force_break_o <= 1'b0;
			tag_opcode_o  <= 1'b0;
		end
		else
		begin
			force_break_o <= force_pend_r && insn_boundary_i && halt_permit_r;
			tag_opcode_o  <= hit && !force_sel_r;
			enter_halt_o  <= halt_permit_r && !cpu_i.halted && !enter_halt_o
				&& (halt_req_i || (force_pend_r && insn_boundary_i)
				|| (queue_end_i && break_en_r && !force_sel_r));
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_permit_frozen;
		@(posedge core_clk_i) disable iff (rst_i)
		cpu_i.halted |=> $stable(halt_permit_r);
	endproperty
	a_permit_frozen: assert property (p_permit_frozen) else $error("permit changed while halted");

	property p_permit_sticky;
		@(posedge core_clk_i) disable iff (rst_i)
		halt_permit_r |=> halt_permit_r;
	endproperty
	a_permit_sticky: assert property (p_permit_sticky) else $error("permit dropped");

	property p_no_halt_unpermitted;
		@(posedge core_clk_i) disable iff (rst_i)
		!halt_permit_r |=> !enter_halt_o;
	endproperty
	a_no_halt_unpermitted: assert property (p_no_halt_unpermitted) else $error("halt without permit");

	property p_break_off;
		@(posedge core_clk_i) disable iff (rst_i)
		!break_en_r [*2] |=> !tag_opcode_o && !force_break_o;
	endproperty
	a_break_off: assert property (p_break_off) else $error("break while disabled");

	property p_status_read;
		@(posedge core_clk_i) disable iff (rst_i)
		stat_rd |=> rvalid_o && (rdata_o[SDC_BIT_HALTED] == $past(cpu_i.halted))
			&& !rdata_o[SDC_BIT_SLOW_FAIL];
	endproperty
	a_status_read: assert property (p_status_read) else $error("bad status read");

	property p_break_write;
		@(posedge core_clk_i) disable iff (rst_i)
		brk_wr |=> break_match_r == $past(cmd_i.wdata);
	endproperty
	a_break_write: assert property (p_break_write) else $error("break match not loaded");

	property p_sleep_fail;
		@(posedge core_clk_i) disable iff (rst_i)
		mem_cmd_i && sleep_conflict_i |=> sleep_fail;
	endproperty
	a_sleep_fail: assert property (p_sleep_fail) else $error("sleep fail not set");

	property p_clk_sel;
		@(posedge core_clk_i) disable iff (rst_i)
		ctrl_wr |=> clk_sel_o == $past(cmd_i.wdata[SDC_BIT_CLK_SEL]);
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("clock select not written");

	property p_ctrl_write;
		@(posedge core_clk_i) disable iff (rst_i)
		ctrl_wr |=> (break_en_r == $past(cmd_i.wdata[SDC_BIT_BREAK_EN]))
			&& (force_sel_r == $past(cmd_i.wdata[SDC_BIT_FORCE_SEL]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control bits not written");

	property p_halt_pulse;
		@(posedge core_clk_i) disable iff (rst_i)
		enter_halt_o |=> !enter_halt_o;
	endproperty
	a_halt_pulse: assert property (p_halt_pulse) else $error("halt entry not a pulse");

	property p_halt_request;
		@(posedge core_clk_i) disable iff (rst_i)
		halt_req_i && halt_permit_r && !cpu_i.halted && !enter_halt_o |=> enter_halt_o;
	endproperty
	a_halt_request: assert property (p_halt_request) else $error("halt request lost");

	property p_force_halt;
		@(posedge core_clk_i) disable iff (rst_i)
		force_pend_r && insn_boundary_i && halt_permit_r && !cpu_i.halted && !enter_halt_o
			|=> enter_halt_o && force_break_o;
	endproperty
	a_force_halt: assert property (p_force_halt) else $error("forced break not taken");

	property p_tag_halt;
		@(posedge core_clk_i) disable iff (rst_i)
		queue_end_i && break_en_r && !force_sel_r && halt_permit_r && !cpu_i.halted
			&& !enter_halt_o |=> enter_halt_o;
	endproperty
	a_tag_halt: assert property (p_tag_halt) else $error("tagged opcode not halted");

	property p_sleep_read;
		@(posedge core_clk_i) disable iff (rst_i)
		stat_rd && cpu_i.sleeping |=> rdata_o[SDC_BIT_SLEEP];
	endproperty
	a_sleep_read: assert property (p_sleep_read) else $error("sleep status not shown");

	property p_status_byte;
		@(posedge core_clk_i) disable iff (rst_i)
		stat_rd |=> (rdata_o[15:8] == 8'h00)
			&& (rdata_o[SDC_BIT_HALT_PERMIT] == $past(halt_permit_r));
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("status byte malformed");

	property p_break_read;
		@(posedge core_clk_i) disable iff (rst_i)
		cmd_i.valid && (cmd_i.code == SDC_CMD_BREAK_READ)
			|=> rvalid_o && (rdata_o == $past(break_match_r));
	endproperty
	a_break_read: assert property (p_break_read) else $error("break match read wrong");

endmodule // sdc_regs

`default_nettype wire

// ===== serial_debug_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module serial_debug_control_regs_tb;
	import sdc_pkg::*;

	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	sdc_cmd_s    cmd;
	sdc_cpu_s    cpu        = '0;
	logic        halt_req   = 1'b0;
	logic        insn_b     = 1'b0;
	logic        q_end      = 1'b0;
	logic        mem_cmd    = 1'b0;
	logic        conflict   = 1'b0;
	logic        rvalid;
	logic [15:0] rdata;
	logic        enter_halt;
	logic        force_brk;
	logic        tag_op;
	logic        clk_sel;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	// ********
	// Clock, watchdog, instances
	// ********
	always #10 core_clk_i = ~core_clk_i;

	// Ceiling well above the roughly 170 cycles the run needs
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			complete_run();
		end
	end

	sdc_host_model i_host (.core_clk_i(core_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
		.cmd_o(cmd));

	sdc_regs i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd), .cpu_i(cpu),
		.halt_req_i(halt_req), .insn_boundary_i(insn_b), .queue_end_i(q_end),
		.mem_cmd_i(mem_cmd), .sleep_conflict_i(conflict), .rvalid_o(rvalid),
		.rdata_o(rdata), .enter_halt_o(enter_halt), .force_break_o(force_brk),
		.tag_opcode_o(tag_op), .clk_sel_o(clk_sel));

	// ********
	// Shared tasks
	// ********
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] wd);
		logic [15:0] v;
		i_host.issue(code, wd, v);
	endtask

	task automatic rd_stat(input logic [15:0] exp);
		logic [15:0] v;
		i_host.issue(SDC_CMD_STATUS_READ, 16'h0000, v);
		check("status", v, exp);
	endtask

	// Events seen over n cycles: {halt entry, forced break, tag}
	task automatic watch(input int n, output logic [2:0] ev);
		ev = '0;
		repeat (n)
		begin
			#1;
			ev |= {enter_halt, force_brk, tag_op};
			@(posedge core_clk_i);
		end
	endtask

	task automatic set_cpu(input logic h, input logic s, input logic v, input logic [15:0] a);
		@(posedge core_clk_i);
		cpu <= '{halted: h, sleeping: s, addr_valid: v, addr: a};
	endtask

	task automatic req_halt(output logic [2:0] ev);
		@(posedge core_clk_i);
		halt_req <= 1'b1;
		@(posedge core_clk_i);
		halt_req <= 1'b0;
		watch(4, ev);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		logic [15:0] v;
		rd_stat(16'h0000);
		i_host.issue(SDC_CMD_BREAK_READ, 16'h0000, v);
		check("match", v, SDC_RST_BREAK);
		check("clk_sel", {15'h0000, clk_sel}, 16'h0000);
	endtask

	task automatic t_refuse;
		logic [2:0] ev;
		req_halt(ev);
		check("no_halt", {13'h0000, ev}, 16'h0000);
		set_cpu(1'b1, 1'b0, 1'b0, 16'h0000);
		wr(SDC_CMD_CONTROL_WR, 16'h0080);
		rd_stat(16'h0040);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
	endtask

	task automatic t_ctrl;
		wr(SDC_CMD_CONTROL_WR, 16'h00FF);
		rd_stat(16'h00B8);
		check("clk_sel", {15'h0000, clk_sel}, 16'h0001);
		wr(SDC_CMD_CONTROL_WR, 16'h0000);
		rd_stat(16'h0080);
		check("clk_sel", {15'h0000, clk_sel}, 16'h0000);
	endtask

	task automatic t_halt;
		logic [2:0] ev;
		req_halt(ev);
		check("halt", {15'h0000, ev[2]}, 16'h0001);
		set_cpu(1'b1, 1'b0, 1'b0, 16'h0000);
		rd_stat(16'h00C0);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
	endtask

	task automatic t_break;
		logic [15:0] v;
		set_cpu(1'b1, 1'b0, 1'b0, 16'h0000);
		wr(SDC_CMD_BREAK_WR, 16'hA5C3);
		i_host.issue(SDC_CMD_BREAK_READ, 16'h0000, v);
		check("match", v, 16'hA5C3);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
	endtask

	// Breakpoint off, then forced, then tagged, all at the same address
	task automatic t_bp;
		logic [2:0] ev;
		wr(SDC_CMD_CONTROL_WR, 16'h0090);
		insn_b <= 1'b1;
		set_cpu(1'b0, 1'b0, 1'b1, 16'hA5C3);
		watch(6, ev);
		check("bp_off", {13'h0000, ev}, 16'h0000);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
		wr(SDC_CMD_CONTROL_WR, 16'h00B0);
		set_cpu(1'b0, 1'b0, 1'b1, 16'hA5C3);
		watch(6, ev);
		check("force", {14'h0000, ev[2], ev[1]}, 16'h0003);
		// CPU obeys the halt, which drops the pending forced break
		set_cpu(1'b1, 1'b0, 1'b0, 16'h0000);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
		insn_b <= 1'b0;
		wr(SDC_CMD_CONTROL_WR, 16'h00A0);
		set_cpu(1'b0, 1'b0, 1'b1, 16'hA5C3);
		watch(4, ev);
		check("tag", {14'h0000, ev[2], ev[0]}, 16'h0001);
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
		q_end <= 1'b1;
		@(posedge core_clk_i);
		q_end <= 1'b0;
		watch(3, ev);
		check("tag_halt", {15'h0000, ev[2]}, 16'h0001);
	endtask

	task automatic t_sleep;
		logic [2:0] ev;
		wr(SDC_CMD_CONTROL_WR, 16'h0080);
		set_cpu(1'b0, 1'b1, 1'b0, 16'h0000);
		rd_stat(16'h0084);
		mem_cmd  <= 1'b1;
		conflict <= 1'b1;
		@(posedge core_clk_i);
		mem_cmd  <= 1'b0;
		conflict <= 1'b0;
		rd_stat(16'h0086);
		req_halt(ev);
		check("wake", {15'h0000, ev[2]}, 16'h0001);
		set_cpu(1'b1, 1'b0, 1'b0, 16'h0000);
		rd_stat(16'h00C4);
		// Retry the failed access while halted, then resume the program
		mem_cmd <= 1'b1;
		@(posedge core_clk_i);
		mem_cmd <= 1'b0;
		set_cpu(1'b0, 1'b0, 1'b0, 16'h0000);
		rd_stat(16'h0080);
	endtask

	task automatic complete_run;
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_refuse();
		t_ctrl();
		t_halt();
		t_break();
		t_bp();
		t_sleep();
		// Second reset mid-run must clear every control bit again
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		complete_run();
	end
endmodule // serial_debug_control_regs_tb

`default_nettype wire
